// ===== core_exec_pkg.sv
package core_exec_pkg;

    localparam int          NUM_REGS     = 16;
    localparam int          DATA_W       = 8;
    localparam int          PC_W         = 16;
    localparam int          APB_AW       = 12;

    // register file indices
    localparam logic [3:0]  REG_IPH      = 4'hC;
    localparam logic [3:0]  REG_IPL      = 4'hD;
    localparam logic [3:0]  REG_STAT     = 4'hE;
    localparam logic [3:0]  REG_ACC      = 4'hF;
    localparam int          GIE_BIT      = 5;

    localparam logic [15:0] PC_RESET     = 16'h0000;
    localparam logic [15:0] PC_STEP      = 16'h0001;
    localparam logic [7:0]  BYTE_ZERO    = 8'h00;
    localparam logic [7:0]  BYTE_ONE     = 8'h01;
    localparam logic [7:0]  BYTE_ONES    = 8'hFF;
    localparam logic [7:0]  SIGN_MIN     = 8'h80;
    localparam logic [7:0]  SIGN_MAX     = 8'h7F;

    // software-visible registers
    localparam logic [11:0] ADDR_CTRL    = 12'h000;
    localparam logic [11:0] ADDR_STATUS  = 12'h004;
    localparam int          CTRL_RUN_BIT = 0;
    localparam int          ST_ILL_BIT   = 3;
    localparam logic        RUN_RESET    = 1'b1;

    typedef enum logic [4:0] {
        OP_NOP   = 5'h00,
        OP_JUMP  = 5'h01,
        OP_JCC   = 5'h02,
        OP_CALL  = 5'h03,
        OP_CALLS = 5'h04,
        OP_RET   = 5'h05,
        OP_RETS  = 5'h06,
        OP_RETI  = 5'h07,
        OP_PUSH  = 5'h08,
        OP_POP   = 5'h09,
        OP_MOVE  = 5'h0A,
        OP_STORE = 5'h0B,
        OP_CMVD  = 5'h0C,
        OP_CMVS  = 5'h0D,
        OP_SHL   = 5'h0E,
        OP_SHLC  = 5'h0F,
        OP_SHR   = 5'h10,
        OP_SHRC  = 5'h11,
        OP_SHRA  = 5'h12,
        OP_ONES_COMPLEMENT  = 5'h13,
        OP_TWOS_COMPLEMENT_NEGATE  = 5'h14,
        OP_NEGATE_WITH_BORROW = 5'h15,
        OP_INC   = 5'h16,
        OP_INCC  = 5'h17,
        OP_DEC   = 5'h18
    } op_t;

    typedef enum logic [2:0] {
        COND_CS  = 3'h0,
        COND_CC  = 3'h1,
        COND_ZS  = 3'h2,
        COND_ZC  = 3'h3,
        COND_VS  = 3'h4,
        COND_VC  = 3'h5,
        COND_ALW = 3'h6,
        COND_NEV = 3'h7
    } cond_t;

    typedef enum logic [1:0] {
        SRC_IMM  = 2'h0,
        SRC_REG  = 2'h1,
        SRC_DM   = 2'h2
    } src_t;

endpackage

// ===== unary_alu.sv
`timescale 1ns/100ps

module unary_alu
    import core_exec_pkg::*;
(
    input  op_t        op,
    input  logic [7:0] src,
    input  logic       cin,
    output logic [7:0] res,
    output logic       cout,
    output logic       vout
);

    always_comb begin
        res  = src;
        cout = cin;
        vout = 1'b0;
        unique case (op)
            OP_SHL: begin
                res  = {src[6:0], 1'b0};
                cout = src[7];
                vout = src[7] ^ src[6];
            end
            OP_SHLC: begin
                res  = {src[6:0], cin};
                cout = src[7];
                vout = src[7] ^ src[6];
            end
            OP_SHR: begin
                res  = {1'b0, src[7:1]};
                cout = src[0];
                vout = src[7];
            end
            OP_SHRC: begin
                res  = {cin, src[7:1]};
                cout = src[0];
                vout = cin ^ src[7];
            end
            OP_SHRA: begin
                // sign kept, so a signed halving never overflows
                res  = {src[7], src[7:1]};
                cout = src[0];
                vout = 1'b0;
            end
            OP_ONES_COMPLEMENT: begin
                res  = ~src;
            end
            OP_TWOS_COMPLEMENT_NEGATE: begin
                res  = ~src + BYTE_ONE;
                cout = (res == BYTE_ZERO);
                vout = (src == SIGN_MIN);
            end
            OP_NEGATE_WITH_BORROW: begin
                res  = ~src + {7'h00, cin};
                cout = (res == BYTE_ZERO) && cin;
                vout = cin && (src == SIGN_MIN);
            end
            OP_INC: begin
                res  = src + BYTE_ONE;
                cout = (res == BYTE_ZERO);
                vout = (src == SIGN_MAX);
            end
            OP_INCC: begin
                res  = src + {7'h00, cin};
                cout = (res == BYTE_ZERO) && cin;
                vout = cin && (src == SIGN_MAX);
            end
            OP_DEC: begin
                res  = src - BYTE_ONE;
                cout = (res != BYTE_ONES);
                vout = (src == SIGN_MIN);
            end
            default: begin
                res  = src;
                cout = cin;
                vout = 1'b0;
            end
        endcase
    end

endmodule

// ===== core_exec.sv
// Local design decisions: the APB slave port and the placing of the registers.
`timescale 1ns/100ps

// Behaviour
// - jump loads PC from target when condition holds
// - call pushes stack, stores PC+1, jumps
// - index call saves PC+1 in index; return uses it
// - interrupt return pops and sets interrupt enable
// - push moves index register onto return stack
// - pop loads index register from stack top
// - loads write dest and acc, zero only
// - carry-conditional move: acc always, dest conditional
// - left shift inserts zero, bit7 to carry
// - left shift through carry inserts old carry
// - right shifts: zero or carry into bit7
// - arithmetic right shift keeps sign bit
// - ones complement updates zero flag only
// - negate sets carry only on zero result
// - negate with carry: carry if zero and cin
// - increment sets carry on wrap to zero
// - increment by carry keeps carry on wrap
// - decrement clears carry on borrow to FF
// - zero flag mirrors accumulator equal to zero once acc is written; after reset acc is zero, flag clear
// - overflow flag set on signed overflow
// - sixteen 8-bit registers, index pairs as 16-bit
module core_exec
    import core_exec_pkg::*;
#(
    parameter int RS_DEPTH = 8,
    parameter int DM_AW    = 16
) (
    input  logic              sys_clk,
    input  logic              rst_n,
    // register bus
    input  logic [APB_AW-1:0] paddr,
    input  logic              psel,
    input  logic              penable,
    input  logic              pwrite,
    input  logic [31:0]       pwdata,
    output logic [31:0]       prdata,
    output logic              pready,
    output logic              pslverr,
    // decoded instruction at progAddr
    input  op_t               insnOp,
    input  cond_t             insnCond,
    input  src_t              insnSrcSel,
    input  logic              insnUseIp,
    input  logic [3:0]        insnDst,
    input  logic [3:0]        insnSrc,
    input  logic [15:0]       insnImm,
    input  logic [DM_AW-1:0]  insnEaddr,
    input  logic [7:0]        dmRdData,
    // memories
    output logic [PC_W-1:0]   progAddr,
    output logic [DM_AW-1:0]  dmAddr,
    output logic [7:0]        dmWrData,
    output logic              dmWrEn,
    // observed core state
    output logic [7:0]        accOut,
    output logic              carryFlag,
    output logic              zeroFlag,
    output logic              ovfFlag,
    output logic              globalIrqEnable,
    output logic              illegalOp,
    output logic              running
);

    typedef struct packed {
        logic [PC_W-1:0]                pc;
        logic [RS_DEPTH-1:0][PC_W-1:0]  returnLifo;
        logic [NUM_REGS-1:0][DATA_W-1:0] rf;
        logic                           c;
        logic                           v;
        logic                           z;
        logic                           illegal;
        logic                           run;
        logic [DM_AW-1:0]               dmAddr;
        logic [7:0]                     dmWrData;
        logic                           dmWrEn;
        logic                           pready;
        logic                           pslverr;
        logic [31:0]                    prdata;
    } state_t;

    state_t      st;
    state_t      next_st;

    logic [15:0] programIndex;
    logic [15:0] pcPlusOne;
    logic [15:0] target;
    logic [7:0]  operand;
    logic        condTrue;
    logic [7:0]  aluRes;
    logic        aluCarry;
    logic        aluOvf;
    logic        busWrite;

    unary_alu u_alu (
        .op   (insnOp),
        .src  (operand),
        .cin  (st.c),
        .res  (aluRes),
        .cout (aluCarry),
        .vout (aluOvf)
    );

    always_comb begin
        programIndex = {st.rf[REG_IPH], st.rf[REG_IPL]};
        pcPlusOne    = st.pc + PC_STEP;
        target       = insnUseIp ? programIndex : insnImm;
        unique case (insnSrcSel)
            SRC_IMM: operand = insnImm[7:0];
            SRC_REG: operand = st.rf[insnSrc];
            SRC_DM:  operand = dmRdData;
            default: operand = BYTE_ZERO;
        endcase
        unique case (insnCond)
            COND_CS:  condTrue = st.c;
            COND_CC:  condTrue = !st.c;
            COND_ZS:  condTrue = st.z;
            COND_ZC:  condTrue = !st.z;
            COND_VS:  condTrue = st.v;
            COND_VC:  condTrue = !st.v;
            COND_ALW: condTrue = 1'b1;
            COND_NEV: condTrue = 1'b0;
        endcase
        busWrite = psel && penable && pwrite && st.pready;
    end

    always_comb begin
        next_st         = st;
        next_st.dmWrEn  = 1'b0;
        next_st.pready  = 1'b0;
        next_st.pslverr = 1'b0;

        // bus writes land at the access-phase edge with pready high
        if (busWrite) begin
            if (paddr == ADDR_CTRL) begin
                next_st.run = pwdata[CTRL_RUN_BIT];
            end else if (paddr == ADDR_STATUS) begin
                if (pwdata[ST_ILL_BIT]) begin
                    next_st.illegal = 1'b0;
                end
            end
        end

        // setup phase: answer is registered, pready high next cycle
        if (psel && !penable) begin
            next_st.pready = 1'b1;
            next_st.prdata = 32'h0000_0000;
            if (paddr == ADDR_CTRL) begin
                next_st.prdata[CTRL_RUN_BIT] = st.run;
            end else if (paddr == ADDR_STATUS) begin
                next_st.prdata = {st.pc, st.rf[REG_ACC], 4'h0,
                                  st.illegal, st.v, st.z, st.c};
            end else begin
                next_st.pslverr = 1'b1;
            end
        end

        // halted core leaves PC and state alone
        if (st.run) begin
            next_st.pc = pcPlusOne;
            unique case (insnOp)
                OP_NOP: begin
                    next_st.pc = pcPlusOne;
                end
                OP_JUMP: begin
                    next_st.pc = target;
                end
                OP_JCC: begin
                    if (condTrue) begin
                        next_st.pc = target;
                    end
                end
                OP_CALL: begin
                    for (int i = RS_DEPTH - 1; i > 0; i--) begin
                        next_st.returnLifo[i] = st.returnLifo[i-1];
                    end
                    next_st.returnLifo[0] = pcPlusOne;
                    next_st.pc            = target;
                end
                OP_CALLS: begin
                    // target already sampled old index for the ip form
                    next_st.rf[REG_IPH] = pcPlusOne[15:8];
                    next_st.rf[REG_IPL] = pcPlusOne[7:0];
                    next_st.pc          = target;
                end
                OP_RET, OP_RETI: begin
                    next_st.pc = st.returnLifo[0];
                    // bottom entry keeps its value on a pop
                    for (int i = 0; i < RS_DEPTH - 1; i++) begin
                        next_st.returnLifo[i] = st.returnLifo[i+1];
                    end
                    if (insnOp == OP_RETI) begin
                        next_st.rf[REG_STAT][GIE_BIT] = 1'b1;
                    end
                end
                OP_RETS: begin
                    next_st.pc = programIndex;
                end
                OP_PUSH: begin
                    for (int i = RS_DEPTH - 1; i > 0; i--) begin
                        next_st.returnLifo[i] = st.returnLifo[i-1];
                    end
                    next_st.returnLifo[0] = programIndex;
                end
                OP_POP: begin
                    next_st.rf[REG_IPH] = st.returnLifo[0][15:8];
                    next_st.rf[REG_IPL] = st.returnLifo[0][7:0];
                    for (int i = 0; i < RS_DEPTH - 1; i++) begin
                        next_st.returnLifo[i] = st.returnLifo[i+1];
                    end
                end
                OP_MOVE: begin
                    next_st.rf[insnDst] = operand;
                    next_st.rf[REG_ACC] = operand;
                    next_st.z = (operand == BYTE_ZERO);
                end
                OP_STORE: begin
                    // no flag changes on a store
                    next_st.dmAddr   = insnEaddr;
                    next_st.dmWrData = operand;
                    next_st.dmWrEn   = 1'b1;
                end
                OP_CMVD, OP_CMVS: begin
                    if ((insnOp == OP_CMVD) != st.c) begin
                        next_st.rf[insnDst] = operand;
                    end
                    next_st.rf[REG_ACC] = operand;
                    next_st.z = (operand == BYTE_ZERO);
                end
                OP_ONES_COMPLEMENT: begin
                    next_st.rf[insnDst] = aluRes;
                    next_st.rf[REG_ACC] = aluRes;
                    next_st.z = (aluRes == BYTE_ZERO);
                end
                OP_SHL, OP_SHLC, OP_SHR, OP_SHRC, OP_SHRA,
                OP_TWOS_COMPLEMENT_NEGATE, OP_NEGATE_WITH_BORROW, OP_INC, OP_INCC, OP_DEC: begin
                    next_st.rf[insnDst] = aluRes;
                    next_st.rf[REG_ACC] = aluRes;
                    next_st.c = aluCarry;
                    next_st.v = aluOvf;
                    next_st.z = (aluRes == BYTE_ZERO);
                end
                default: begin
                    // unknown opcode runs as a step; set beats clear
                    next_st.illegal = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st     <= '0;
            st.pc  <= PC_RESET;
            st.run <= RUN_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign prdata          = st.prdata;
    assign pready          = st.pready;
    assign pslverr         = st.pslverr;
    assign progAddr        = st.pc;
    assign dmAddr          = st.dmAddr;
    assign dmWrData        = st.dmWrData;
    assign dmWrEn          = st.dmWrEn;
    assign accOut          = st.rf[REG_ACC];
    assign carryFlag       = st.c;
    assign zeroFlag        = st.z;
    assign ovfFlag         = st.v;
    assign globalIrqEnable = st.rf[REG_STAT][GIE_BIT];
    assign illegalOp       = st.illegal;
    assign running         = st.run;

endmodule

// ===== prog_data_mem.sv
`timescale 1ns/100ps

module prog_data_mem
    import core_exec_pkg::*;
#(
    parameter int DM_AW = 16
) (
    input  logic             sys_clk,
    input  logic [PC_W-1:0]  progAddr,
    input  logic [DM_AW-1:0] dmAddr,
    input  logic [7:0]       dmWrData,
    input  logic             dmWrEn,
    output op_t              insnOp,
    output cond_t            insnCond,
    output src_t             insnSrcSel,
    output logic             insnUseIp,
    output logic [3:0]       insnDst,
    output logic [3:0]       insnSrc,
    output logic [15:0]      insnImm,
    output logic [DM_AW-1:0] insnEaddr,
    output logic [7:0]       dmRdData
);
    typedef struct packed {
        op_t         op;
        cond_t       cd;
        src_t        sl;
        logic        ip;
        logic [3:0]  d;
        logic [3:0]  s;
        logic [15:0] im;
    } word_t;
    // filled by the bench before each reset; 33 and 34 are patched while running
    word_t      rom [128];
    logic [7:0] dm [256];
    word_t      w;

    assign w = rom[progAddr[6:0]];
    assign insnOp = w.op;
    assign insnCond = w.cd;
    assign insnSrcSel = w.sl;
    assign insnUseIp = w.ip;
    assign insnDst = w.d;
    assign insnSrc = w.s;
    assign insnImm = w.im;
    // the immediate doubles as data address, so stores take a register
    assign insnEaddr = DM_AW'(w.im);
    assign dmRdData = dm[insnEaddr[7:0]];

    always @(posedge sys_clk) begin
        if (dmWrEn)
            dm[dmAddr[7:0]] <= dmWrData;
    end
endmodule

// ===== core_exec_checker.sv
`timescale 1ns/100ps

module core_exec_checker
    import core_exec_pkg::*;
#(
    parameter int RS_DEPTH = 8,
    parameter int DM_AW    = 16
) (
    input logic             sys_clk,
    input logic             rst_n,
    input op_t              insnOp,
    input src_t             insnSrcSel,
    input logic             insnUseIp,
    input logic [15:0]      insnImm,
    input logic [DM_AW-1:0] insnEaddr,
    input logic [PC_W-1:0]  progAddr,
    input logic [DM_AW-1:0] dmAddr,
    input logic             dmWrEn,
    input logic [7:0]       accOut,
    input logic             carryFlag,
    input logic             zeroFlag,
    input logic             ovfFlag,
    input logic             globalIrqEnable,
    input logic             running
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    jump_target_a: assert property (
        running && insnOp == OP_JUMP && !insnUseIp
        |=> progAddr == $past(insnImm)) else $error("jump target missed");
    seq_step_a: assert property (
        running && insnOp inside {OP_PUSH, OP_POP, OP_MOVE}
        |=> progAddr == $past(progAddr) + PC_STEP) else $error("no step");
    call_return_a: assert property (
        running && insnOp == OP_CALL && !insnUseIp ##1
        running && insnOp == OP_RET
        |=> progAddr == $past(progAddr, 2) + PC_STEP)
        else $error("call return address wrong");
    link_return_a: assert property (
        running && insnOp == OP_CALLS && !insnUseIp ##1
        running && insnOp == OP_RETS
        |=> progAddr == $past(progAddr, 2) + PC_STEP)
        else $error("index link return wrong");
    reti_enable_a: assert property (
        running && insnOp == OP_RETI |=> globalIrqEnable)
        else $error("interrupt enable not set");
    zero_mirror_a: assert property (
        running && insnOp inside {OP_MOVE, OP_CMVD, OP_ONES_COMPLEMENT, OP_INC, OP_DEC}
        |=> zeroFlag == (accOut == BYTE_ZERO)) else $error("zero flag wrong");
    ones_complement_flags_a: assert property (
        running && insnOp == OP_ONES_COMPLEMENT |=> $stable(carryFlag) && $stable(ovfFlag))
        else $error("complement touched carry");
    shl_imm_a: assert property (
        running && insnOp == OP_SHL && insnSrcSel == SRC_IMM
        |=> carryFlag == |($past(insnImm) & 16'h0080)
        && accOut == 8'($past(insnImm) << 1)) else $error("shift wrong");
    store_write_a: assert property (
        running && insnOp == OP_STORE |=> dmWrEn
        && dmAddr == $past(insnEaddr) && $stable(zeroFlag))
        else $error("store pulse wrong");
endmodule

bind core_exec core_exec_checker #(.RS_DEPTH(RS_DEPTH), .DM_AW(DM_AW))
    i_core_exec_checker (.*);

// ===== core_exec_test.sv
`timescale 1ns/100ps

module core_exec_test
    import core_exec_pkg::*;
;
    typedef struct packed {
        op_t        op;
        logic [7:0] src;
        logic       cin;
        logic [7:0] acc;
        logic [1:0] cv;
        logic [7:0] dst;
    } row_t;
    // dst is what the destination holds; it starts at 55
    localparam row_t ROWS [21] = '{
        '{OP_MOVE,8'h00,1'h1,8'h00,2'h3,8'h00},
        '{OP_CMVD,8'h33,1'h1,8'h33,2'h3,8'h55},
        '{OP_CMVD,8'h33,1'h0,8'h33,2'h0,8'h33},
        '{OP_CMVS,8'h33,1'h1,8'h33,2'h3,8'h33},
        '{OP_CMVS,8'h33,1'h0,8'h33,2'h0,8'h55},
        '{OP_SHL,8'h81,1'h0,8'h02,2'h3,8'h02},
        '{OP_SHLC,8'h40,1'h1,8'h81,2'h1,8'h81},
        '{OP_SHR,8'h01,1'h1,8'h00,2'h2,8'h00},
        '{OP_SHRC,8'h02,1'h1,8'h81,2'h1,8'h81},
        '{OP_SHRA,8'h81,1'h0,8'hC0,2'h2,8'hC0},
        '{OP_ONES_COMPLEMENT,8'h0F,1'h1,8'hF0,2'h3,8'hF0},
        '{OP_TWOS_COMPLEMENT_NEGATE,8'h00,1'h0,8'h00,2'h2,8'h00},
        '{OP_TWOS_COMPLEMENT_NEGATE,8'h80,1'h0,8'h80,2'h1,8'h80},
        '{OP_NEGATE_WITH_BORROW,8'h00,1'h1,8'h00,2'h2,8'h00},
        '{OP_NEGATE_WITH_BORROW,8'h00,1'h0,8'hFF,2'h0,8'hFF},
        '{OP_INC,8'hFF,1'h0,8'h00,2'h2,8'h00},
        '{OP_INC,8'h7F,1'h0,8'h80,2'h1,8'h80},
        '{OP_INCC,8'hFF,1'h1,8'h00,2'h2,8'h00},
        '{OP_INCC,8'hFF,1'h0,8'hFF,2'h0,8'hFF},
        '{OP_DEC,8'h00,1'h1,8'hFF,2'h0,8'hFF},
        '{OP_DEC,8'h80,1'h0,8'h7F,2'h3,8'h7F}};
    localparam logic [15:0] PCS [17] = '{16'h00, 16'h01, 16'h08, 16'h09,
        16'h10, 16'h0A, 16'h0B, 16'h0C, 16'h14, 16'h02, 16'h03, 16'h04,
        16'h05, 16'h20, 16'h24, 16'h21, 16'h21};

    logic        sys_clk, rst_n, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    op_t         insnOp;
    cond_t       insnCond;
    src_t        insnSrcSel;
    logic        insnUseIp, dmWrEn, carryFlag, zeroFlag, ovfFlag;
    logic        globalIrqEnable, illegalOp, running;
    logic [3:0]  insnDst, insnSrc;
    logic [15:0] insnImm, insnEaddr, progAddr, dmAddr;
    logic [7:0]  dmRdData, dmWrData, accOut;
    logic [32:0] rd;
    int          miscompares = 0;
    int          samplesChecked = 0;

    core_exec #(.RS_DEPTH(8), .DM_AW(16)) i_core_exec (.*);
    prog_data_mem #(.DM_AW(16)) i_prog_data_mem (.*);

    task automatic giveVerdict();
        $display("checks %0d, mismatches %0d", samplesChecked, miscompares);
        if (miscompares == 0 && samplesChecked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic put(input int a, input op_t op, input logic [15:0] im = 0,
            input src_t sl = SRC_IMM, input logic [3:0] d = 0,
            input logic [3:0] s = 0, input cond_t cd = COND_NEV,
            input logic ip = 0);
        i_prog_data_mem.rom[a] = '{op, cd, sl, ip, d, s, im};
    endtask

    task automatic stepTo(input logic [15:0] a);
        for (int i = 0; i < 40 && progAddr !== a; i++) begin
            @(posedge sys_clk);
            #1;
        end
        check(progAddr, a);
    endtask

    task automatic doReset();
        @(posedge sys_clk);
        rst_n <= 1'h0;
        repeat (16) @(posedge sys_clk);
        check({progAddr, accOut, running, globalIrqEnable, dmWrEn, pready},
            {16'h0000, 8'h00, 4'h8});
        rst_n <= 1'h1;
        #1;
    endtask

    // waits on pready itself; only the watchdog ends a stuck transfer
    task automatic apb(input logic w, input logic [11:0] a,
            input logic [31:0] d, output logic [32:0] r);
        @(posedge sys_clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'h1;
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'h1);
        r = {pslverr, prdata};
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    initial begin
        sys_clk = 1'h0;
        forever #20 sys_clk = ~sys_clk;
    end

    initial begin
        repeat (5000) @(posedge sys_clk);
        miscompares++;
        giveVerdict();
    end

    initial begin
        rst_n = 1'h0;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        foreach (i_prog_data_mem.rom[k]) i_prog_data_mem.rom[k] = '0;
        // each row: preset dest, load source, set carry, operate, read dest
        for (int k = 0; k < 21; k++) begin
            put(5 * k, OP_MOVE, 16'h0055, SRC_IMM, 4'h2);
            put(5 * k + 1, OP_MOVE, {8'h00, ROWS[k].src}, SRC_IMM, 4'h1);
            put(5 * k + 2, OP_SHL, {8'h00, ROWS[k].cin, 7'h00}, SRC_IMM, 4'h3);
            put(5 * k + 3, ROWS[k].op, 16'h0000, SRC_REG, 4'h2, 4'h1);
            put(5 * k + 4, OP_MOVE, 16'h0000, SRC_REG, 4'h5, 4'h2);
        end
        doReset();
        for (int k = 0; k < 21; k++) begin
            stepTo(16'(5 * k + 4));
            check(accOut, ROWS[k].acc);
            check({carryFlag, ovfFlag}, ROWS[k].cv);
            check(zeroFlag, ROWS[k].acc == 8'h00);
            stepTo(16'(5 * k + 5));
            check(accOut, ROWS[k].dst);
        end
        foreach (i_prog_data_mem.rom[k]) i_prog_data_mem.rom[k] = '0;
        put(0, OP_MOVE, 16'h0014, SRC_IMM, REG_IPL);
        put(1, OP_CALL, 16'h0008);
        put(8, OP_PUSH);
        put(9, OP_CALLS, 16'h0010);
        put(16, OP_RETS);
        put(10, OP_POP);
        put(11, OP_JCC, 16'h0030, SRC_IMM, 4'h0, 4'h0, COND_ZS);
        put(12, OP_JCC, 16'h0000, SRC_IMM, 4'h0, 4'h0, COND_ALW, 1'h1);
        put(20, OP_RETI);
        put(2, OP_STORE, 16'h0040, SRC_REG, 4'h0, REG_IPL);
        put(3, OP_MOVE, 16'h0000, SRC_IMM, 4'h1);
        put(4, OP_MOVE, 16'h0040, SRC_DM, 4'h0);
        put(5, OP_JCC, 16'h0020, SRC_IMM, 4'h0, 4'h0, COND_ZC);
        put(32, OP_CALL, 16'h0024);
        put(36, OP_RET);
        put(33, OP_JUMP, 16'h0021);
        doReset();
        for (int i = 0; i < 17; i++) begin
            check(progAddr, PCS[i]);
            if (PCS[i] == 16'h0003)
                check({dmWrEn, dmAddr[7:0], dmWrData}, {1'h1, 8'h40, 8'h14});
            @(posedge sys_clk);
            #1;
        end
        check({globalIrqEnable, accOut}, {1'h1, 8'h14});
        apb(1'h0, ADDR_STATUS, 32'h0, rd);
        check(rd, {1'h0, 32'h0021_1400});
        apb(1'h1, ADDR_CTRL, 32'h0, rd);
        #1;
        check(running, 1'h0);
        apb(1'h0, 12'h008, 32'h0, rd);
        check(rd, {1'h1, 32'h0});
        apb(1'h1, ADDR_CTRL, 32'h1, rd);
        apb(1'h0, ADDR_CTRL, 32'h0, rd);
        check(rd, {1'h0, 32'h1});
        // unknown opcode at 33, then park at 34 on a taken overflow-clear jump
        #1;
        put(34, OP_JCC, 16'h0022, SRC_IMM, 4'h0, 4'h0, COND_VC);
        put(33, op_t'(5'h1F));
        repeat (2) @(posedge sys_clk);
        #1;
        check({illegalOp, progAddr}, {1'h1, 16'h0022});
        apb(1'h0, ADDR_STATUS, 32'h0, rd);
        check(rd, {1'h0, 32'h0022_1408});
        apb(1'h1, ADDR_STATUS, 32'h0000_0008, rd);
        #1;
        check(illegalOp, 1'h0);
        giveVerdict();
    end
endmodule
